// ### pkg/prs_pkg.sv
// What this block does
// - visit pods in order effluent, return, filter, access on every run
// - run air pump until air-side pressure matches the pod-side pressure
// - open the pod valve only once pressures match
// - inject until pressure moves 50 mmHg and holds for 2 seconds
// - at end of travel withdraw a metered 1 cc of air
// - fail when post pressure differs from pre pressure by over 50 mmHg
// - one pod at a time, advance when finished, stop after last pod
// - a run serves both periodic and prime self-tests
// - faults show through the general self-test fail flag, with the pod in fail_pod
// - negative pods and positive pods use mirrored step directions
// - sensor readings are limited to -250..+250 mmHg
// - return and filter rise 50 mmHg, access and effluent fall 50 mmHg
// - each pod gets at most 45 seconds, else fail
package prs_pkg;

  localparam int unsigned PW          = 10;     // signed mmHg
  localparam int unsigned NPOD        = 4;
  localparam longint     CLK_HZ      = 10_000_000;
  localparam longint     HOLD_MS     = 2000;
  localparam longint     LIMIT_S     = 45;
  localparam int unsigned HOLD_CYC    = 32'(HOLD_MS * CLK_HZ / 1000);
  localparam int unsigned LIMIT_CYC   = 32'(LIMIT_S * CLK_HZ);
  localparam int          STEP_MMHG   = 50;     // travel detect step
  localparam int          VERIFY_MMHG = 50;     // post vs pre limit
  localparam int          MATCH_MMHG  = 2;      // equalisation window
  localparam int          SPAN_MMHG   = 250;    // sensor span, both signs
  // pods 0..3 are effluent, return, filter, access; set bit = negative pod
  localparam logic [3:0]  NEG_PODS    = 4'h9;
  localparam logic [1:0]  LAST_POD    = 2'h3;

  typedef logic signed [PW-1:0] prs_press_t;

  typedef struct packed {
    logic run;   // pump motor on
    logic fill;  // 1 pushes air toward the pod, 0 draws air back
  } prs_pump_t;

  typedef enum logic [2:0] {
    S_IDLE, S_MATCH, S_TRAVEL, S_BACK, S_VERIFY
  } prs_state_t;

endpackage

// ### logic/prs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module prs_sequencer #(
  parameter int unsigned HOLD_CYC  = prs_pkg::HOLD_CYC,
  parameter int unsigned LIMIT_CYC = prs_pkg::LIMIT_CYC
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       start,
  input  wire logic                       prime_run,
  input  wire prs_pkg::prs_press_t [3:0]  pod_press,
  input  wire prs_pkg::prs_press_t        sensor_press,
  input  wire logic                       move_done,
  output prs_pkg::prs_pump_t              pump,
  output logic                            move_req,
  output logic [3:0]                      valve_open,
  output logic                            busy,
  output logic                            done,
  output logic                            fail,
  output logic                            prime_tag,
  output logic [1:0]                      fail_pod
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks: hold must fit inside the per-pod limit
  generate
    if (HOLD_CYC < 1 || LIMIT_CYC <= HOLD_CYC) begin : g_bad
      $error("prs_sequencer: HOLD_CYC must be >=1 and below LIMIT_CYC");
    end
  endgenerate

  // clamp a reading to the sensor span
  function automatic logic signed [11:0] sat(input prs_pkg::prs_press_t p);
    logic signed [11:0] w;
    w = 12'(p);
    if (w > 12'(prs_pkg::SPAN_MMHG)) begin
      sat = 12'(prs_pkg::SPAN_MMHG);
    end else if (w < -12'(prs_pkg::SPAN_MMHG)) begin
      sat = -12'(prs_pkg::SPAN_MMHG);
    end else begin
      sat = w;
    end
  endfunction

  // magnitude of a difference between two clamped readings
  function automatic logic [11:0] absdiff(input logic signed [11:0] a,
                                          input logic signed [11:0] b);
    logic signed [11:0] d;
    d = a - b;
    absdiff = (d < 0) ? 12'(-d) : 12'(d);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  prs_pkg::prs_state_t state;
  logic [1:0]          pod;
  logic signed [11:0]  pre;       // pod pressure before repositioning
  logic signed [11:0]  base;      // sensor level when the valve opened
  logic [31:0]         hold_cnt;
  logic [31:0]         tmo_cnt;

  // decode of the present reading against the captured levels
  wire logic signed [11:0] sen      = sat(sensor_press);
  wire logic               neg_pod  = prs_pkg::NEG_PODS[pod];
  wire logic [11:0]        match_d  = absdiff(sen, pre);
  wire logic               matched  = match_d <= 12'(prs_pkg::MATCH_MMHG);
  wire logic signed [11:0] moved    = neg_pod ? base - sen : sen - base;
  // negative pods look for a fall, positive pods for a rise
  wire logic               stepped  =
    moved >= 12'(prs_pkg::STEP_MMHG);
  wire logic               hold_ok  = hold_cnt >= HOLD_CYC - 1;
  wire logic               timeout  = tmo_cnt >= LIMIT_CYC - 1;
  wire logic               bad_post =
    match_d > 12'(prs_pkg::VERIFY_MMHG);
  wire logic               last_pod = pod == prs_pkg::LAST_POD;
  wire logic               active   = state != prs_pkg::S_IDLE;
  wire logic signed [11:0] pre_next = sat(pod_press[pod + 2'h1]);

  ////////////////////////////////////////////////////////////////////////
  // per-pod time limit, restarted whenever a new pod is taken up
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tmo_cnt <= 32'h0000_0000;
    end else if (!active || state == prs_pkg::S_VERIFY) begin
      tmo_cnt <= 32'h0000_0000;
    end else begin
      tmo_cnt <= tmo_cnt + 32'h0000_0001;
    end
  end

  // end-of-travel hold: any dip below the step restarts the 2 s window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= 32'h0000_0000;
    end else if (state != prs_pkg::S_TRAVEL || !stepped) begin
      hold_cnt <= 32'h0000_0000;
    end else if (!hold_ok) begin
      hold_cnt <= hold_cnt + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer; every output is a flop so the pump and valve drivers
  // never see decode glitches
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state      <= prs_pkg::S_IDLE;
      pod        <= 2'h0;
      pre        <= 12'h000;
      base       <= 12'h000;
      pump       <= '0;
      move_req   <= 1'b0;
      valve_open <= 4'h0;
      busy       <= 1'b0;
      done       <= 1'b0;
      fail       <= 1'b0;
      prime_tag  <= 1'b0;
      fail_pod   <= 2'h0;
    end else begin
      done     <= 1'b0;
      move_req <= 1'b0;
      if (active && timeout) begin
        // quiet everything and report through the common flag in the same cycle
        state      <= prs_pkg::S_IDLE;
        pump       <= '0;
        valve_open <= 4'h0;
        busy       <= 1'b0;
        done       <= 1'b1;
        fail       <= 1'b1;
        fail_pod   <= pod;
      end else begin
        case (state)
          prs_pkg::S_IDLE: begin
            pump       <= '0;
            valve_open <= 4'h0;
            // a start while busy cannot land here, so it is ignored
            if (start) begin
              state     <= prs_pkg::S_MATCH;
              pod       <= 2'h0;
              pre       <= sat(pod_press[0]);
              busy      <= 1'b1;
              fail      <= 1'b0;
              prime_tag <= prime_run;
            end
          end
          prs_pkg::S_MATCH: begin
            if (matched) begin
              pump          <= '0;
              valve_open    <= 4'h0;
              valve_open[pod] <= 1'b1;
              base          <= sen;
              state         <= prs_pkg::S_TRAVEL;
            end else begin
              // drive air side toward the pod side reading
              pump <= '{run: 1'b1, fill: sen < pre};
            end
          end
          prs_pkg::S_TRAVEL: begin
            // the last sample of the window must still be past the step,
            // or a dip on the final cycle would slip through
            if (hold_ok && stepped) begin
              // reverse by one metered volume to centre the diaphragm
              pump     <= '{run: 1'b0, fill: neg_pod};
              move_req <= 1'b1;
              state    <= prs_pkg::S_BACK;
            end else begin
              pump <= '{run: 1'b1, fill: !neg_pod};
            end
          end
          prs_pkg::S_BACK: begin
            if (move_done) begin
              state <= prs_pkg::S_VERIFY;
            end
          end
          prs_pkg::S_VERIFY: begin
            valve_open <= 4'h0;
            pump       <= '0;
            if (bad_post) begin
              state    <= prs_pkg::S_IDLE;
              busy     <= 1'b0;
              done     <= 1'b1;
              fail     <= 1'b1;
              fail_pod <= pod;
            end else if (last_pod) begin
              state <= prs_pkg::S_IDLE;
              busy  <= 1'b0;
              done  <= 1'b1;
            end else begin
              pod   <= pod + 2'h1;
              pre   <= pre_next;
              state <= prs_pkg::S_MATCH;
            end
          end
          default: begin
            state <= prs_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks kept beside the logic they guard
  a_valve_one_hot: assert property (
    @(posedge clock) disable iff (!rst_n) $onehot0(valve_open))
    else $error("more than one pod valve open");

  a_valve_after_match: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(|valve_open) |-> $past(state == prs_pkg::S_MATCH && matched))
    else $error("valve opened before pressures matched");

  a_pod_order: assert property (
    @(posedge clock) disable iff (!rst_n)
    ($changed(pod) && busy && $past(busy)) |-> pod == $past(pod) + 2'h1)
    else $error("pod visited out of order");

  a_back_after_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    move_req |-> $past(state == prs_pkg::S_TRAVEL && stepped)
                 && $past(hold_cnt) >= HOLD_CYC - 1)
    else $error("withdraw before end of travel hold");

  a_withdraw_dir: assert property (
    @(posedge clock) disable iff (!rst_n)
    move_req |-> !pump.run && pump.fill == neg_pod
                 ##1 state == prs_pkg::S_BACK)
    else $error("metered withdraw in wrong direction");

  a_verify_fail: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state == prs_pkg::S_VERIFY && bad_post && !timeout)
      |=> done && fail && valve_open == 4'h0)
    else $error("post pressure error not reported");

  a_travel_dir: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state == prs_pkg::S_TRAVEL && $past(state) == prs_pkg::S_TRAVEL
     && !move_req) |-> pump.run && pump.fill == !neg_pod)
    else $error("travel pump direction wrong for pod type");

  a_timeout_fail: assert property (
    @(posedge clock) disable iff (!rst_n)
    (active && timeout) |=> done && fail && !busy && !pump.run)
    else $error("pod time limit not enforced");

  a_idle_quiet: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state == prs_pkg::S_IDLE && $past(state) == prs_pkg::S_IDLE)
      |-> valve_open == 4'h0 && !pump.run)
    else $error("pump or valve active while idle");

  // a new start may land in the done cycle, so busy is only checked there
  a_done_pulse: assert property (
    @(posedge clock) disable iff (!rst_n) done |-> !busy ##1 !done)
    else $error("done longer than one cycle");

  a_match_pump_dir: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state == prs_pkg::S_MATCH && !matched && !timeout)
      |=> pump.run && pump.fill == $past(sen < pre))
    else $error("equalisation pump not driven toward pod pressure");

  a_start_first_pod: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(busy) |-> pod == 2'h0 && state == prs_pkg::S_MATCH)
    else $error("run did not begin at the effluent pod");

  a_prime_capture: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(busy) |-> prime_tag == $past(prime_run))
    else $error("prime flag not captured with start");

  a_fail_with_done: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(fail) |-> done)
    else $error("fail raised outside the done pulse");

  a_hold_restart: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(state == prs_pkg::S_TRAVEL && stepped) |=> hold_cnt == 32'h0000_0000)
    else $error("hold window not restarted after a dip");

  // withdraw only once the sensor has moved a full step the right way
  a_step_sign: assert property (
    @(posedge clock) disable iff (!rst_n)
    move_req |-> (neg_pod ? $past(sen) + 12'(prs_pkg::STEP_MMHG) <= base
                          : $past(sen) >= base + 12'(prs_pkg::STEP_MMHG)))
    else $error("end of travel taken before a full step");

  a_start_taken: assert property (
    @(posedge clock) disable iff (!rst_n)
    (start && state == prs_pkg::S_IDLE) |=> busy && !fail)
    else $error("start from idle not taken");

  a_fail_quiet: assert property (
    @(posedge clock) disable iff (!rst_n)
    (done && fail) |-> !pump.run && valve_open == 4'h0)
    else $error("failure reported with pump or valve active");

  a_verify_advance: assert property (
    @(posedge clock) disable iff (!rst_n)
    (state == prs_pkg::S_VERIFY && !bad_post && !last_pod && !timeout)
      |=> state == prs_pkg::S_MATCH && pod == $past(pod) + 2'h1
          && valve_open == 4'h0)
    else $error("sequencer did not advance to the next pod");

endmodule
`default_nettype wire

// ### test/prs_air_model.sv
`timescale 1ns/100ps
`default_nettype none
module prs_air_model (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire prs_pkg::prs_pump_t        pump,
  input  wire logic                      move_req,
  input  wire logic [3:0]                valve_open,
  input  wire prs_pkg::prs_press_t [3:0] pod_press,
  input  wire prs_pkg::prs_press_t       offset,
  input  wire logic [1:0]                bad_pod,
  input  wire logic                      stall,
  input  wire logic [7:0]                move_delay,
  output var prs_pkg::prs_press_t        sensor_press,
  output var logic                       move_done
);
  logic [7:0] wait_cnt;
  //////////////////////////////////////////////////////////////////////////
  // pod lookup; the error lands on one pod only so a fault stops mid-run
  wire [1:0] pod_idx = {valve_open[3] | valve_open[2],
                        valve_open[3] | valve_open[1]};
  wire prs_pkg::prs_press_t next_move = pump.fill ?
    sensor_press + 10'sh001 : sensor_press - 10'sh001;
  wire prs_pkg::prs_press_t landed = (pod_idx == bad_pod) ?
    pod_press[pod_idx] + offset : pod_press[pod_idx];
  //////////////////////////////////////////////////////////////////////////
  // pump moves 1 mmHg a cycle; stall models a dead pump for the time limit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sensor_press <= '0;
      wait_cnt <= 8'h00;
      move_done <= 1'b0;
    end else begin
      move_done <= (wait_cnt == 8'h01);
      if (wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
        if (wait_cnt == 8'h01) sensor_press <= landed;
      end else if (move_req) begin
        wait_cnt <= move_delay;
      end else if (pump.run && !stall) begin
        sensor_press <= next_move;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int unsigned HOLD  = 8;
  localparam int unsigned LIMIT = 1000;
  logic clock, rst_n, start, prime_run, move_done, move_req;
  logic busy, done, fail, prime_tag, stall;
  logic [3:0] valve_open;
  logic [1:0] fail_pod, bad_pod;
  logic [7:0] move_delay;
  prs_pkg::prs_press_t [3:0] pod_press;
  prs_pkg::prs_press_t sensor_press, offset;
  prs_pkg::prs_pump_t pump;
  int num_errors, cmp_count;

  prs_sequencer #(.HOLD_CYC(HOLD), .LIMIT_CYC(LIMIT)) dut_u (
    .clock(clock), .rst_n(rst_n), .start(start), .prime_run(prime_run),
    .pod_press(pod_press), .sensor_press(sensor_press),
    .move_done(move_done), .pump(pump), .move_req(move_req),
    .valve_open(valve_open), .busy(busy), .done(done), .fail(fail),
    .prime_tag(prime_tag), .fail_pod(fail_pod));
  prs_air_model air_u (
    .clock(clock), .rst_n(rst_n), .pump(pump), .move_req(move_req),
    .valve_open(valve_open), .pod_press(pod_press), .offset(offset),
    .bad_pod(bad_pod), .stall(stall), .move_delay(move_delay),
    .sensor_press(sensor_press), .move_done(move_done));

  //////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one run; a second start at cycle 5 lands while busy and must vanish
  task automatic run(input logic prm, input logic xfail, input logic [1:0]
                     xpod, input int xmov, input logic [7:0] xord,
                     input int min_cyc);
    logic [7:0] order;
    logic [3:0] last_v;
    logic [1:0] i;
    prs_pkg::prs_press_t prev;
    int n, nmov, d;
    order = 8'h00;
    last_v = 4'h0;
    nmov = 0;
    prev = sensor_press;
    @(posedge clock);
    prime_run <= prm;
    start <= 1'b1;
    // the first pass must not stop on the done pulse of the run before
    for (n = 0; n < 6000 && (n == 0 || done !== 1'b1); n++) begin
      @(posedge clock);
      start <= (n == 5);
      #1;
      i = {valve_open[3] | valve_open[2], valve_open[3] | valve_open[1]};
      chk("one pod", 16'h1, $onehot0(valve_open));
      if (valve_open != 4'h0 && valve_open !== last_v) begin
        order = {order[5:0], i};
        d = int'(prev) - int'(pod_press[i]);
        chk("matched", 16'h1, d <= 2 && d >= -2);
      end
      if (pump.run === 1'b1 && valve_open != 4'h0)
        chk("direction", !prs_pkg::NEG_PODS[i], pump.fill);
      nmov += int'(move_req);
      last_v = valve_open;
      prev = sensor_press;
    end
    if (done !== 1'b1) begin
      num_errors++;
      $display("[FAIL] run hung");
      conclude();
    end
    chk("fail", xfail, fail);
    if (xfail) chk("fail pod", xpod, fail_pod);
    chk("moves", xmov, nmov);
    chk("order", xord, order);
    chk("long enough", 16'h1, n >= min_cyc);
    chk("prime tag", prm, prime_tag);
    chk("quiet", 16'h0, {busy, pump.run, valve_open});
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_periodic;
    offset <= '0;
    stall <= 1'b0;
    move_delay <= 8'h02;
    run(1'b0, 1'b0, 2'h0, 4, 8'h1b, 4 * (HOLD + 4));
    $display("test periodic finished");
  endtask

  // slow pump driver and a verify error right at the limit
  task automatic t_prime_edge;
    offset <= 10'sh032;
    bad_pod <= 2'h3;
    move_delay <= 8'h28;
    run(1'b1, 1'b0, 2'h0, 4, 8'h1b, 4 * (HOLD + 4));
    $display("test prime edge finished");
  endtask

  task automatic t_verify_fail;
    offset <= -10'sh033;
    bad_pod <= 2'h2;
    run(1'b1, 1'b1, 2'h2, 3, 8'h06, 3 * (HOLD + 4));
    $display("test verify fail finished");
  endtask

  task automatic t_timeout;
    stall <= 1'b1;
    run(1'b0, 1'b1, 2'h0, 0, 8'h00, LIMIT - 2);
    $display("test timeout finished");
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    num_errors = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    start = 1'b0;
    prime_run = 1'b0;
    pod_press = {-10'sh028, 10'sh03c, 10'sh078, -10'sh050};
    offset = '0;
    bad_pod = 2'h0;
    stall = 1'b0;
    move_delay = 8'h02;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_periodic();
    t_prime_edge();
    t_verify_fail();
    t_timeout();
    conclude();
  end
endmodule
`default_nettype wire
